//--- gpp_pkg.sv
// shared constants and carrier types for the two-port gpio configuration block
package gpp_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_P4_EVENT_STATUS = 8'hE8;
	localparam logic [7:0] OFS_P5_FUNCTION_SELECT = 8'hEB;
	localparam logic [7:0] OFS_P4_FUNCTION_SELECT = 8'hEE;
	localparam logic [7:0] OFS_P4_DIRECTION = 8'hF0;
	localparam logic [7:0] OFS_P4_DATA = 8'hF1;
	localparam logic [7:0] OFS_P4_INVERSION = 8'hF2;
	localparam logic [7:0] OFS_P5_DIRECTION = 8'hF4;
	localparam logic [7:0] OFS_P5_DATA = 8'hF5;
	localparam logic [7:0] OFS_P5_INVERSION = 8'hF6;
	localparam logic [7:0] OFS_P5_EVENT_STATUS = 8'hF7;
	localparam logic [7:0] OFS_INPUT_DETECT_TYPE = 8'hFE;

	// values after reset
	localparam logic [7:0] RST_P4_DIRECTION = 8'hFF;
	localparam logic [4:0] RST_P5_DIRECTION = 5'h1F;
	localparam logic [7:0] RST_ZERO8 = 8'h00;
	localparam logic [4:0] RST_ZERO5 = 5'h00;

	// field positions in the input detect type register
	localparam int DET_DEBOUNCE_OFF_BIT = 4;
	localparam int DET_LEVEL_TRIG_BIT = 0;
	// position of the filtered pin inside port four
	localparam int P4_FILTERED_PIN = 1;

	// debounce settle time in ns and derived cycle count at 100 MHz
	localparam int CLK_PERIOD_NS = 10;
	localparam int DEBOUNCE_NS = 160;
	localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} gpp_bus_req_t;

	// alternate function sources that a pin may carry instead of plain data
	typedef struct packed {
		logic watchdog_timeout_out;
		logic yellow_led_out;
		logic green_led_out;
		logic beep;
		logic management_interrupt_out;
	} gpp_func_t;
endpackage

//--- gpp_port_pair.sv
// port four / port five configuration, pin drive, debounce and event capture
`timescale 1ns/1ps
module gpp_port_pair #(
	parameter int DEBOUNCE_CYCLES = gpp_pkg::DEBOUNCE_CYCLES
) (
	// clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// per-port master resets from the standby well, active high, synchronous
	input wire logic port_four_master_reset_i,
	input wire logic port_five_master_reset_i,
	input wire logic port_nine_master_reset_i,
	// register port
	input wire gpp_pkg::gpp_bus_req_t bus_i,
	output logic [7:0] rdata_o,
	// alternate function sources
	input wire gpp_pkg::gpp_func_t func_i,
	// port four pins
	input wire logic [7:0] port_four_in_i,
	output logic [7:0] port_four_out_o,
	output logic [7:0] port_four_oe_o,
	// port five pins
	input wire logic [4:0] port_five_in_i,
	output logic [4:0] port_five_out_o,
	output logic [4:0] port_five_oe_o
);

	// counter wide enough to hold the full settle count
	localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);

	// software visible registers
	logic [7:0] p4_dir;
	logic [7:0] p4_data;
	logic [7:0] p4_inv;
	logic [7:0] p4_fsel;
	logic [7:0] p4_stat;
	logic [4:0] p5_dir;
	logic [4:0] p5_data;
	logic [4:0] p5_inv;
	logic [4:0] p5_fsel;
	logic [4:0] p5_stat;
	logic [7:0] det_type;

	// pin history and debouncer
	logic [7:0] p4_prev;
	logic [4:0] p5_prev;
	logic pin41_stable;
	logic [CW-1:0] deb_cnt;

	// combinational views
	logic [7:0] p4_pin;
	logic [7:0] p4_view;
	logic [4:0] p5_view;
	logic [7:0] p4_event;
	logic [4:0] p5_event;
	logic [7:0] next_p4_out;
	logic [7:0] next_p4_oe;
	logic [4:0] next_p5_out;
	logic [4:0] next_p5_oe;
	logic [7:0] next_rdata;
	logic wr_p4;
	logic wr_p5;
	logic clr_p4_stat;
	logic clr_p5_stat;
	// port five results worked at full byte width, then cut to five bits
	logic [7:0] p5_data_wr;
	logic [7:0] p5_stat_next;

	// write of an i/o data register touches only pins set as outputs,
	// so a write never disturbs a pin that software has left to the board
	function automatic logic [7:0] merge_out(input logic [7:0] old, input logic [7:0] wd,
			input logic [7:0] dir);
		merge_out = (old & dir) | (wd & ~dir);
	endfunction

	// sticky status update: clear only what was read, new events win;
	// an event in the cycle of the clearing read therefore survives
	function automatic logic [7:0] stat_update(input logic [7:0] old, input logic clr,
			input logic [7:0] ev);
		stat_update = (clr ? 8'h00 : old) | ev;
	endfunction

	// bus decode strobes; the status clear has no enable term of its own
	// because the status flops only move while the enable is high
	assign wr_p4 = bus_i.wr && ce_i;
	assign wr_p5 = bus_i.wr && ce_i;
	assign clr_p4_stat = bus_i.rd && (bus_i.addr == gpp_pkg::OFS_P4_EVENT_STATUS);
	assign clr_p5_stat = bus_i.rd && (bus_i.addr == gpp_pkg::OFS_P5_EVENT_STATUS);

	// port five values widened to a byte for the shared helpers
	assign p5_data_wr = merge_out({3'h0, p5_data}, bus_i.wdata, {3'h7, p5_dir});
	assign p5_stat_next = stat_update({3'h0, p5_stat}, clr_p5_stat, {3'h0, p5_event});

	// pin 41 debouncer; the raw pin must hold its new level for the full
	// settle count before the filtered copy follows, so short glitches vanish;
	// the filter trades a settle delay for immunity to contact bounce
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i || port_four_master_reset_i) begin
			// start from the pin's own level so release brings no false edge
			pin41_stable <= port_four_in_i[gpp_pkg::P4_FILTERED_PIN];
			deb_cnt <= '0;
		end else if (ce_i) begin
			if (det_type[gpp_pkg::DET_DEBOUNCE_OFF_BIT]) begin
				// bypassed: the filtered copy simply follows the pin
				pin41_stable <= port_four_in_i[gpp_pkg::P4_FILTERED_PIN];
				deb_cnt <= '0;
			end else if (port_four_in_i[gpp_pkg::P4_FILTERED_PIN] == pin41_stable) begin
				// a return to the stable level restarts the count
				deb_cnt <= '0;
			end else if (deb_cnt >= CW'(DEBOUNCE_CYCLES - 1)) begin
				pin41_stable <= port_four_in_i[gpp_pkg::P4_FILTERED_PIN];
				deb_cnt <= '0;
			end else begin
				deb_cnt <= deb_cnt + CW'(1);
			end
		end
	end

	// pin values as software sees them, pin 41 through the filter,
	// so with the debouncer on a glitch on pin 41 never reaches status or data
	always_comb begin
		p4_pin = port_four_in_i;
		p4_pin[gpp_pkg::P4_FILTERED_PIN] = pin41_stable;
		p4_view = p4_pin ^ p4_inv;
		p5_view = port_five_in_i ^ p5_inv;
	end

	// event detection on either edge; pin 41 may instead trigger on level
	// edge events look at the uninverted pin, so changing the inversion alone flags nothing except pin 41 in level mode
	always_comb begin
		p4_event = p4_pin ^ p4_prev;
		if (det_type[gpp_pkg::DET_LEVEL_TRIG_BIT]) begin
			// level mode keeps flagging while the active level stands
			p4_event[gpp_pkg::P4_FILTERED_PIN] = p4_view[gpp_pkg::P4_FILTERED_PIN];
		end
		p5_event = port_five_in_i ^ p5_prev;
	end

	// pin history for edge detection; it follows the pins during reset, so the
	// first enabled edge after release compares like with like and flags nothing
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			p4_prev <= p4_pin;
			p5_prev <= port_five_in_i;
		end else if (ce_i) begin
			p4_prev <= p4_pin;
			p5_prev <= port_five_in_i;
		end
	end

	// port four configuration registers
	// writes to unmapped offsets fall through and are dropped
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i || port_four_master_reset_i) begin
			p4_dir <= gpp_pkg::RST_P4_DIRECTION;
			p4_data <= gpp_pkg::RST_ZERO8;
			p4_inv <= gpp_pkg::RST_ZERO8;
			p4_fsel <= gpp_pkg::RST_ZERO8;
		end else if (wr_p4) begin
			if (bus_i.addr == gpp_pkg::OFS_P4_DIRECTION) begin
				p4_dir <= bus_i.wdata;
			end else if (bus_i.addr == gpp_pkg::OFS_P4_DATA) begin
				p4_data <= merge_out(p4_data, bus_i.wdata, p4_dir);
			end else if (bus_i.addr == gpp_pkg::OFS_P4_INVERSION) begin
				p4_inv <= bus_i.wdata;
			end else if (bus_i.addr == gpp_pkg::OFS_P4_FUNCTION_SELECT) begin
				p4_fsel <= bus_i.wdata;
			end
		end
	end

	// port five configuration registers, low five bits only
	// bits 7 to 5 of every port five write are dropped
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i || port_five_master_reset_i) begin
			p5_dir <= gpp_pkg::RST_P5_DIRECTION;
			p5_data <= gpp_pkg::RST_ZERO5;
			p5_inv <= gpp_pkg::RST_ZERO5;
			p5_fsel <= gpp_pkg::RST_ZERO5;
		end else if (wr_p5) begin
			if (bus_i.addr == gpp_pkg::OFS_P5_DIRECTION) begin
				p5_dir <= bus_i.wdata[4:0];
			end else if (bus_i.addr == gpp_pkg::OFS_P5_DATA) begin
				p5_data <= p5_data_wr[4:0];
			end else if (bus_i.addr == gpp_pkg::OFS_P5_INVERSION) begin
				p5_inv <= bus_i.wdata[4:0];
			end else if (bus_i.addr == gpp_pkg::OFS_P5_FUNCTION_SELECT) begin
				// bit 0 is reserved and never stored
				p5_fsel <= {bus_i.wdata[4:1], 1'b0};
			end
		end
	end

	// detect type register; either port four or port nine master reset clears it
	// only bits 4 and 0 are kept; the rest read back as zero
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i || port_four_master_reset_i || port_nine_master_reset_i) begin
			det_type <= gpp_pkg::RST_ZERO8;
		end else if (wr_p4 && bus_i.addr == gpp_pkg::OFS_INPUT_DETECT_TYPE) begin
			det_type <= bus_i.wdata & 8'h11;
		end
	end

	// sticky event status; the cleared image is exactly the one returned
	// the read and its clear share one strobe, so no bit is lost unseen
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i || port_four_master_reset_i) begin
			p4_stat <= gpp_pkg::RST_ZERO8;
		end else if (ce_i) begin
			p4_stat <= stat_update(p4_stat, clr_p4_stat, p4_event);
		end
	end

	// port five status, same scheme on the five implemented pins
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i || port_five_master_reset_i) begin
			p5_stat <= gpp_pkg::RST_ZERO5;
		end else if (ce_i) begin
			p5_stat <= p5_stat_next[4:0];
		end
	end

	// pin drive: a selected alternate function overrides plain data and
	// forces the driver on, whatever the direction bit says
	// alternate sources carry their own polarity, so no inversion is applied
	always_comb begin
		next_p4_out = p4_data ^ p4_inv;
		next_p4_oe = ~p4_dir;
		// both halves of port four share one pattern, so one loop covers them
		for (int i = 0; i < 2; i++) begin
			if (p4_fsel[4*i+3]) begin
				next_p4_out[4*i+3] = func_i.yellow_led_out;
				next_p4_oe[4*i+3] = 1'b1;
			end
			if (p4_fsel[4*i+2]) begin
				next_p4_out[4*i+2] = func_i.beep;
				next_p4_oe[4*i+2] = 1'b1;
			end
			if (p4_fsel[4*i+1]) begin
				next_p4_out[4*i+1] = func_i.management_interrupt_out;
				next_p4_oe[4*i+1] = 1'b1;
			end
			if (p4_fsel[4*i]) begin
				next_p4_out[4*i] = func_i.watchdog_timeout_out;
				next_p4_oe[4*i] = 1'b1;
			end
		end
		next_p5_out = p5_data ^ p5_inv;
		next_p5_oe = ~p5_dir;
		if (p5_fsel[4]) begin
			next_p5_out[4] = func_i.watchdog_timeout_out;
			next_p5_oe[4] = 1'b1;
		end
		if (p5_fsel[3]) begin
			next_p5_out[3] = func_i.green_led_out;
			next_p5_oe[3] = 1'b1;
		end
		if (p5_fsel[2]) begin
			next_p5_out[2] = func_i.beep;
			next_p5_oe[2] = 1'b1;
		end
		if (p5_fsel[1]) begin
			next_p5_out[1] = func_i.management_interrupt_out;
			next_p5_oe[1] = 1'b1;
		end
	end

	// registered pin drivers, one cycle behind the configuration
	// master resets leave them alone; they follow the reset configuration a cycle later
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			port_four_out_o <= gpp_pkg::RST_ZERO8;
			port_four_oe_o <= gpp_pkg::RST_ZERO8;
			port_five_out_o <= gpp_pkg::RST_ZERO5;
			port_five_oe_o <= gpp_pkg::RST_ZERO5;
		end else if (ce_i) begin
			port_four_out_o <= next_p4_out;
			port_four_oe_o <= next_p4_oe;
			port_five_out_o <= next_p5_out;
			port_five_oe_o <= next_p5_oe;
		end
	end

	// read mux; reserved and unmapped bits read as zero
	// an input pin reads its pin level through the inversion, an output pin the value software stored
	always_comb begin
		next_rdata = 8'h00;
		if (bus_i.addr == gpp_pkg::OFS_P4_EVENT_STATUS) begin
			next_rdata = p4_stat;
		end else if (bus_i.addr == gpp_pkg::OFS_P5_FUNCTION_SELECT) begin
			next_rdata = {3'h0, p5_fsel};
		end else if (bus_i.addr == gpp_pkg::OFS_P4_FUNCTION_SELECT) begin
			next_rdata = p4_fsel;
		end else if (bus_i.addr == gpp_pkg::OFS_P4_DIRECTION) begin
			next_rdata = p4_dir;
		end else if (bus_i.addr == gpp_pkg::OFS_P4_DATA) begin
			next_rdata = (p4_view & p4_dir) | (p4_data & ~p4_dir);
		end else if (bus_i.addr == gpp_pkg::OFS_P4_INVERSION) begin
			next_rdata = p4_inv;
		end else if (bus_i.addr == gpp_pkg::OFS_P5_DIRECTION) begin
			next_rdata = {3'h0, p5_dir};
		end else if (bus_i.addr == gpp_pkg::OFS_P5_DATA) begin
			next_rdata = {3'h0, (p5_view & p5_dir) | (p5_data & ~p5_dir)};
		end else if (bus_i.addr == gpp_pkg::OFS_P5_INVERSION) begin
			next_rdata = {3'h0, p5_inv};
		end else if (bus_i.addr == gpp_pkg::OFS_P5_EVENT_STATUS) begin
			next_rdata = {3'h0, p5_stat};
		end else if (bus_i.addr == gpp_pkg::OFS_INPUT_DETECT_TYPE) begin
			next_rdata = det_type;
		end
	end

	// read data stands only in the cycle after the strobe
	// zero outside that slot lets several register blocks share one or-ed return
	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			rdata_o <= gpp_pkg::RST_ZERO8;
		end else if (ce_i) begin
			rdata_o <= bus_i.rd ? next_rdata : 8'h00;
		end
	end

endmodule

//--- gpp_port_pair_monitor.sv
// assertion checker for the gpio port pair, bound to its ports
`timescale 1ns/1ps
module gpp_port_pair_monitor (
	// clock, reset, enables
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic port_four_master_reset_i,
	input wire logic port_five_master_reset_i,
	// register port
	input wire gpp_pkg::gpp_bus_req_t bus_i,
	input wire logic [7:0] rdata_o,
	// pins
	input wire logic [7:0] port_four_in_i,
	input wire logic [7:0] port_four_oe_o,
	input wire logic [4:0] port_five_in_i,
	input wire logic [4:0] port_five_oe_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	// bit 1 is masked where debounce or level mode may add events late
	wire logic rds = ce_i && bus_i.rd;
	wire logic r4 = rds && bus_i.addr == gpp_pkg::OFS_P4_EVENT_STATUS;
	wire logic r5 = rds && bus_i.addr == gpp_pkg::OFS_P5_EVENT_STATUS;
	wire logic q4 = ce_i && !port_four_master_reset_i;
	wire logic q5 = ce_i && !port_five_master_reset_i;
	property p_rdata_idle; ce_i && !bus_i.rd |=> rdata_o == 8'h00; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
	property p_oe_reset;
		$rose(rstn_i) |-> port_four_oe_o == 8'h00 && port_five_oe_o == 5'h00;
	endproperty
	a_oe_reset: assert property (p_oe_reset) else $error("pins driven after reset");
	property p_p4_dir;
		q4 && bus_i.wr && bus_i.addr == gpp_pkg::OFS_P4_DIRECTION ##1 q4 && !bus_i.wr
			|=> (port_four_oe_o | $past(bus_i.wdata, 2)) == 8'hFF;
	endproperty
	a_p4_dir: assert property (p_p4_dir) else $error("output pin not driven");
	property p_p4_clear;
		r4 && $stable(port_four_in_i) ##1 r4 && $stable(port_four_in_i)
			|=> (rdata_o & 8'hFD) == 8'h00;
	endproperty
	a_p4_clear: assert property (p_p4_clear) else $error("status not cleared");
	property p_p4_set;
		q4 && $changed(port_four_in_i) ##1 q4 && r4
			|=> (~rdata_o & ($past(port_four_in_i, 2) ^ $past(port_four_in_i, 3)) & 8'hFD) == 8'h00;
	endproperty
	a_p4_set: assert property (p_p4_set) else $error("port four edge lost");
	property p_p5_set;
		q5 && $changed(port_five_in_i) ##1 q5 && r5
			|=> (~rdata_o[4:0] & ($past(port_five_in_i, 2) ^ $past(port_five_in_i, 3))) == 5'h00;
	endproperty
	a_p5_set: assert property (p_p5_set) else $error("port five edge lost");
	property p_p5_rsv; rds && bus_i.addr inside {[8'hF4:8'hF7], 8'hEB} |=> rdata_o[7:5] == 3'h0;
	endproperty
	a_p5_rsv: assert property (p_p5_rsv) else $error("reserved bits set");
	property p_det_rsv;
		rds && bus_i.addr == gpp_pkg::OFS_INPUT_DETECT_TYPE |=> (rdata_o & 8'hEE) == 8'h00;
	endproperty
	a_det_rsv: assert property (p_det_rsv) else $error("detect reserved set");
endmodule
bind gpp_port_pair gpp_port_pair_monitor u_mon (
	.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
	.port_four_master_reset_i(port_four_master_reset_i),
	.port_five_master_reset_i(port_five_master_reset_i),
	.bus_i(bus_i), .rdata_o(rdata_o),
	.port_four_in_i(port_four_in_i), .port_four_oe_o(port_four_oe_o),
	.port_five_in_i(port_five_in_i), .port_five_oe_o(port_five_oe_o)
);

//--- gpp_board_model.sv
// board pins: a driven pin follows the drive, an undriven one the board level
`timescale 1ns/1ps
module gpp_board_model (
	// drive from the block
	input wire logic [7:0] p4_out_i,
	input wire logic [7:0] p4_oe_i,
	input wire logic [4:0] p5_out_i,
	input wire logic [4:0] p5_oe_i,
	// board levels while undriven
	input wire logic [7:0] p4_ext_i,
	input wire logic [4:0] p5_ext_i,
	// resolved levels
	output logic [7:0] p4_pin_o,
	output logic [4:0] p5_pin_o
);
	// the drive wins so that output pins loop back as events
	assign p4_pin_o = (p4_out_i & p4_oe_i) | (p4_ext_i & ~p4_oe_i);
	assign p5_pin_o = (p5_out_i & p5_oe_i) | (p5_ext_i & ~p5_oe_i);
endmodule

//--- tb_gpp_port_pair.sv
// bench for the gpio port pair: register tasks, pin stimulus, verdict
`timescale 1ns/1ps
module tb_gpp_port_pair;
	logic ref_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic ce = 1'b1;
	logic [2:0] mr = 3'h0;
	logic [7:0] p4_ext = 8'hA5;
	logic [4:0] p5_ext = 5'h0A;
	gpp_pkg::gpp_bus_req_t bus = '0;
	gpp_pkg::gpp_func_t fn = '0;
	logic [7:0] rdata, p4_out, p4_oe, p4_pin;
	logic [4:0] p5_out, p5_oe, p5_pin;
	int n_fail = 0;
	int compares = 0;
	int cycles = 0;
	// offset in the high byte, value after reset in the low byte
	logic [15:0] rt [11] = '{16'hE800, 16'hEB00, 16'hEE00, 16'hF0FF, 16'hF1A5, 16'hF200,
		16'hF41F, 16'hF50A, 16'hF600, 16'hF700, 16'hFE00};
	always #5 ref_clk_i = ~ref_clk_i;
	// short debounce keeps glitch tests brief
	gpp_port_pair #(.DEBOUNCE_CYCLES(2)) u_gpp_port_pair (
		.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce),
		.port_four_master_reset_i(mr[0]), .port_five_master_reset_i(mr[1]),
		.port_nine_master_reset_i(mr[2]), .bus_i(bus), .rdata_o(rdata), .func_i(fn),
		.port_four_in_i(p4_pin), .port_four_out_o(p4_out), .port_four_oe_o(p4_oe),
		.port_five_in_i(p5_pin), .port_five_out_o(p5_out), .port_five_oe_o(p5_oe)
	);
	gpp_board_model u_gpp_board_model (
		.p4_out_i(p4_out), .p4_oe_i(p4_oe), .p5_out_i(p5_out), .p5_oe_i(p5_oe),
		.p4_ext_i(p4_ext), .p5_ext_i(p5_ext), .p4_pin_o(p4_pin), .p5_pin_o(p5_pin)
	);
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk_i);
		bus.wr <= 1'b0;
	endtask
	// read, then compare the masked data in the slot after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge ref_clk_i);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk_i);
		bus.rd <= 1'b0;
		#1 chk(rdata & m, e);
	endtask
	task automatic pulse(input logic [2:0] m);
		@(posedge ref_clk_i);
		mr <= m;
		@(posedge ref_clk_i);
		mr <= 3'h0;
	endtask
	task automatic finish_test;
		if (n_fail == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// hang guard, far above the two hundred or so cycles the run needs
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_fail++;
			finish_test();
		end
	end
	initial begin
		repeat (16) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		foreach (rt[i]) rd(rt[i][15:8], rt[i][7:0], 8'hFF);
		wr(8'hE0, 8'hFF);
		rd(8'hE0, 8'h00, 8'hFF);
		wr(8'hF1, 8'h5A);
		rd(8'hF1, 8'hA5, 8'hFF);
		wr(8'hF2, 8'hFF);
		rd(8'hF1, 8'h5A, 8'hFF);
		// with the enable low a write strobe is lost
		@(posedge ref_clk_i);
		ce <= 1'b0;
		wr(8'hF2, 8'h00);
		ce <= 1'b1;
		rd(8'hF2, 8'hFF, 8'hFF);
		wr(8'hF0, 8'h00);
		wr(8'hF1, 8'h3C);
		repeat (4) @(posedge ref_clk_i);
		#1 chk(p4_out, 8'hC3);
		chk(p4_oe, 8'hFF);
		rd(8'hF1, 8'h3C, 8'hFF);
		rd(8'hE8, 8'h7E, 8'hFF);
		rd(8'hE8, 8'h00, 8'hFF);
		@(posedge ref_clk_i);
		p5_ext <= 5'h15;
		rd(8'hF7, 8'h1F, 8'hFF);
		rd(8'hF7, 8'h00, 8'hFF);
		wr(8'hF6, 8'h1F);
		wr(8'hF4, 8'hE0);
		rd(8'hF4, 8'h00, 8'hFF);
		rd(8'hF5, 8'h00, 8'hFF);
		chk({3'h0, p5_out}, 8'h1F);
		chk({3'h0, p5_oe}, 8'h1F);
		rd(8'hF7, 8'h0A, 8'hFF);
		wr(8'hF5, 8'hFF);
		rd(8'hF5, 8'h1F, 8'hFF);
		wr(8'hEE, 8'hFF);
		wr(8'hEB, 8'hFF);
		rd(8'hEB, 8'h1E, 8'hFF);
		for (int k = 0; k < 2; k++) begin
			@(posedge ref_clk_i);
			fn <= k ? 5'h0A : 5'h15;
			repeat (3) @(posedge ref_clk_i);
			#1 chk(p4_out, k ? 8'hCC : 8'h33);
			chk({3'h0, p5_out}, k ? 8'h04 : 8'h1A);
		end
		wr(8'hEE, 8'h00);
		wr(8'hEB, 8'h00);
		wr(8'hF0, 8'hFF);
		wr(8'hFE, 8'hFF);
		rd(8'hFE, 8'h11, 8'hFF);
		// back-to-back reads: level mode sets bit 1 again after each clear
		@(posedge ref_clk_i);
		bus <= '{addr: 8'hE8, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		repeat (2) @(posedge ref_clk_i);
		bus.rd <= 1'b0;
		#1 chk(rdata & 8'h02, 8'h02);
		// a one-cycle glitch passes only with the debouncer off
		for (int k = 0; k < 3; k++) begin
			wr(8'hFE, k ? 8'h00 : 8'h10);
			rd(8'hE8, 8'h00, 8'h00);
			@(posedge ref_clk_i);
			p4_ext[1] <= 1'b1;
			repeat (k == 2 ? 4 : 1) @(posedge ref_clk_i);
			p4_ext[1] <= 1'b0;
			repeat (4) @(posedge ref_clk_i);
			rd(8'hE8, k == 1 ? 8'h00 : 8'h02, 8'h02);
		end
		@(posedge ref_clk_i);
		p4_ext[7] <= 1'b0;
		fork
			rd(8'hE8, 8'h80, 8'hA0);
			begin
				@(posedge ref_clk_i);
				p4_ext[5] <= 1'b0;
			end
		join
		rd(8'hE8, 8'h20, 8'hA0);
		wr(8'hF0, 8'h0F);
		wr(8'hFE, 8'h11);
		pulse(3'h1);
		rd(8'hF0, 8'hFF, 8'hFF);
		rd(8'hFE, 8'h00, 8'hFF);
		wr(8'hFE, 8'h11);
		pulse(3'h4);
		rd(8'hFE, 8'h00, 8'hFF);
		pulse(3'h2);
		rd(8'hF4, 8'h1F, 8'hFF);
		finish_test();
	end
endmodule
